/* File: hw/unit_status_word_bank.sv */
// read-only status word bank of a modular temperature controller, APB slave
// assumes an APB master on core_clk_i; status inputs come from pins
// Summary of operation
// - channel error word bits 0-3 follow channel 1-4 error.
// - unit error word bits 0-7 follow unit 1-8 zero-cross fault.
// - power-controller unit frequency fault holds the heater current.
// - unit alarm bits follow burnout, overcurrent or shorted relay.
// - power-controller units also alarm on an open relay.
// - output status bits 0-3 mirror control outputs 1-4.
// - linear output variants report outputs 1 and 2 as zero.
// - words sit at indices 000B, 000F, 0010, 0012, 16 bits each.
// - heater current held on short on-time, no CT or CT disabled.
`default_nettype none
`include "unit_status_defs.svh"

module unit_status_word_bank
   import unit_status_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [13:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // interrupt
   output logic             irq_o,
   // channel and unit conditions (asynchronous pins)
   input  wire logic [3:0]  channel_error_i,
   input  wire logic [7:0]  unit_zero_cross_fault_i,
   input  wire logic [7:0]  unit_is_power_ctl_i,
   input  wire logic [7:0]  unit_freq_fault_i,
   input  wire logic [7:0]  unit_heater_burnout_i,
   input  wire logic [7:0]  unit_overcurrent_i,
   input  wire logic [7:0]  unit_relay_short_i,
   input  wire logic [7:0]  unit_relay_open_i,
   input  wire logic [3:0]  control_output_i,
   input  wire logic        ct_connected_i,
   // heater current samples (core_clk_i domain)
   input  wire logic [15:0] heater_sample_i,
   input  wire logic        heater_sample_valid_i,
   input  wire logic        ontime_short_i
);

   // pin synchroniser stages: first stage read only by the second
   localparam int SYNC_W = 4 + 8 * 7 + 4 + 1;
   logic [SYNC_W-1:0] pin_meta_r;
   logic [SYNC_W-1:0] pin_sync_r;

   // synchronised views
   logic [3:0] channel_error_s;
   logic [7:0] zero_cross_s;
   logic [7:0] power_ctl_s;
   logic [7:0] freq_fault_s;
   logic [7:0] burnout_s;
   logic [7:0] overcurrent_s;
   logic [7:0] relay_short_s;
   logic [7:0] relay_open_s;
   logic [3:0] control_output_s;
   logic       ct_connected_s;

   // status words
   status_word_type channel_error_flags_r;
   status_word_type expansion_unit_error_flags_r;
   status_word_type expansion_unit_alarm_flags_r;
   status_word_type control_output_state_r;
   status_word_type channel_error_flags_nxt;
   status_word_type expansion_unit_error_flags_nxt;
   status_word_type expansion_unit_alarm_flags_nxt;
   status_word_type control_output_state_nxt;

   // interrupt and configuration registers
   logic [`IRQ_COUNT-1:0] irq_status_r;
   logic [`IRQ_COUNT-1:0] irq_enable_r;
   logic [`IRQ_COUNT-1:0] irq_event;
   logic [`IRQ_COUNT-1:0] irq_clear;
   logic [1:0]            bank_config_r;
   logic                  holding_prev_r;
   logic                  irq_r;

   // apb state
   logic        pready_r;
   logic        pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rdata_nxt;
   logic        addr_hit;
   logic        access;
   logic        wr_done;
   word_index_type idx;

   heater_hold_if hold_link ();

   // two flip-flops on every pin input; the ct bit resets to its idle,
   // connected level so that no false hold event follows reset
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         pin_meta_r <= {{(SYNC_W-1){1'b0}}, 1'b1};
         pin_sync_r <= {{(SYNC_W-1){1'b0}}, 1'b1};
      end
      else
      begin
         pin_meta_r <= {channel_error_i, unit_zero_cross_fault_i,
                        unit_is_power_ctl_i, unit_freq_fault_i,
                        unit_heater_burnout_i, unit_overcurrent_i,
                        unit_relay_short_i, unit_relay_open_i,
                        control_output_i, ct_connected_i};
         pin_sync_r <= pin_meta_r;
      end
   end

   // split synchronised pins into their fields
   assign {channel_error_s, zero_cross_s, power_ctl_s, freq_fault_s,
           burnout_s, overcurrent_s, relay_short_s, relay_open_s,
           control_output_s, ct_connected_s} = pin_sync_r;

   // next values of the status words, unused bits forced to zero
   always_comb
   begin
      channel_error_flags_nxt        = '0;
      expansion_unit_error_flags_nxt = '0;
      expansion_unit_alarm_flags_nxt = '0;
      control_output_state_nxt       = '0;
      channel_error_flags_nxt[`CHANNEL_COUNT-1:0] = channel_error_s;
      expansion_unit_error_flags_nxt[`UNIT_COUNT-1:0] = zero_cross_s;
      expansion_unit_alarm_flags_nxt[`UNIT_COUNT-1:0] =
         burnout_s | overcurrent_s | relay_short_s |
         (relay_open_s & power_ctl_s);
      control_output_state_nxt[`OUTPUT_COUNT-1:0] = control_output_s;
      // linear variants blank outputs 1 and 2
      if (bank_config_r[`CFG_BIT_LINEAR_OUTPUTS])
      begin
         control_output_state_nxt[1:0] = 2'h0;
      end
   end

   // status words track their conditions every cycle
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         channel_error_flags_r        <= '0;
         expansion_unit_error_flags_r <= '0;
         expansion_unit_alarm_flags_r <= '0;
         control_output_state_r       <= '0;
      end
      else
      begin
         channel_error_flags_r        <= channel_error_flags_nxt;
         expansion_unit_error_flags_r <= expansion_unit_error_flags_nxt;
         expansion_unit_alarm_flags_r <= expansion_unit_alarm_flags_nxt;
         control_output_state_r       <= control_output_state_nxt;
      end
   end

   // heater current hold request
   assign hold_link.sample_value = heater_sample_i;
   assign hold_link.sample_valid = heater_sample_valid_i;
   // short on-time, no CT, CT off, power-controller frequency fault
   assign hold_link.hold_req =
      ontime_short_i | ~ct_connected_s |
      ~bank_config_r[`CFG_BIT_CT_ASSIGN_ENABLE] |
      (|(freq_fault_s & power_ctl_s));

   heater_current_hold u_hold (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .hold_link  (hold_link.monitor)
   );

   // apb decode
   assign idx     = word_index(paddr_i);
   assign access  = psel_i & penable_i;
   assign wr_done = access & pready_r & pwrite_i & addr_hit;

   // mapped addresses and read data
   always_comb
   begin
      addr_hit  = 1'b1;
      rdata_nxt = 32'h0000_0000;
      unique case (idx)
         `IDX_CHANNEL_ERROR_FLAGS:
            rdata_nxt[15:0] = channel_error_flags_r;
         `IDX_EXPANSION_UNIT_ERROR_FLAGS:
            rdata_nxt[15:0] = expansion_unit_error_flags_r;
         `IDX_EXPANSION_UNIT_ALARM_FLAGS:
            rdata_nxt[15:0] = expansion_unit_alarm_flags_r;
         `IDX_CONTROL_OUTPUT_STATE:
            rdata_nxt[15:0] = control_output_state_r;
         `IDX_IRQ_STATUS:
            rdata_nxt[`IRQ_COUNT-1:0] = irq_status_r;
         `IDX_IRQ_ENABLE:
            rdata_nxt[`IRQ_COUNT-1:0] = irq_enable_r;
         `IDX_IRQ_CLEAR:
            rdata_nxt = 32'h0000_0000; // write only
         `IDX_BANK_CONFIG:
            rdata_nxt[1:0] = bank_config_r;
         `IDX_HEATER_CURRENT:
            rdata_nxt[15:0] = hold_link.held_value;
         default:
            addr_hit = 1'b0;
      endcase
      if (paddr_i[1:0] != 2'h0)
      begin
         addr_hit  = 1'b0;
         rdata_nxt = 32'h0000_0000;
      end
   end

   // one wait state, then answer with data and error flag
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else
      begin
         pready_r  <= access & ~pready_r;
         pslverr_r <= access & ~pready_r & ~addr_hit;
         if (access && !pready_r && !pwrite_i && addr_hit)
         begin
            prdata_r <= rdata_nxt;
         end
         else
         begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   // writable registers; status words take no writes
   // ignore writes to status words
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         irq_enable_r  <= `RST_IRQ_ENABLE;
         bank_config_r <= `RST_BANK_CONFIG;
      end
      else if (wr_done && pstrb_i[0])
      begin
         if (idx == `IDX_IRQ_ENABLE)
         begin
            irq_enable_r <= pwdata_i[`IRQ_COUNT-1:0];
         end
         if (idx == `IDX_BANK_CONFIG)
         begin
            bank_config_r <= pwdata_i[1:0];
         end
      end
   end

   // rising conditions raise interrupt events
   always_comb
   begin
      irq_event = '0;
      irq_event[`IRQ_BIT_CHANNEL_ERROR] =
         any_rise({4'h0, channel_error_flags_nxt[3:0]},
                  {4'h0, channel_error_flags_r[3:0]});
      irq_event[`IRQ_BIT_UNIT_ERROR] =
         any_rise(expansion_unit_error_flags_nxt[7:0],
                  expansion_unit_error_flags_r[7:0]);
      irq_event[`IRQ_BIT_UNIT_ALARM] =
         any_rise(expansion_unit_alarm_flags_nxt[7:0],
                  expansion_unit_alarm_flags_r[7:0]);
      irq_event[`IRQ_BIT_HEATER_HOLD] = hold_link.holding & ~holding_prev_r;
   end

   // write-one-to-clear strobe
   assign irq_clear = (wr_done && pstrb_i[0] && idx == `IDX_IRQ_CLEAR) ?
                      pwdata_i[`IRQ_COUNT-1:0] : '0;

   // sticky status: a new event wins over a clear in the same cycle
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         irq_status_r   <= '0;
         holding_prev_r <= 1'b0;
      end
      else
      begin
         irq_status_r   <= (irq_status_r & ~irq_clear) | irq_event;
         holding_prev_r <= hold_link.holding;
      end
   end

   // level interrupt from enabled status bits
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= |(irq_status_r & irq_enable_r);
      end
   end

   // outputs straight from flip-flops
   assign prdata_o  = prdata_r;
   assign pready_o  = pready_r;
   assign pslverr_o = pslverr_r;
   assign irq_o     = irq_r;

endmodule // unit_status_word_bank

`default_nettype wire

/* File: hw/unit_status_defs.svh */
// constants for the unit status word bank: word indices,
// field positions and reset values; assumes inclusion by bare name
`ifndef UNIT_STATUS_DEFS_SVH
`define UNIT_STATUS_DEFS_SVH

// word indices of the status words
`define IDX_CHANNEL_ERROR_FLAGS        12'h00B
`define IDX_EXPANSION_UNIT_ERROR_FLAGS 12'h00F
`define IDX_EXPANSION_UNIT_ALARM_FLAGS 12'h010
`define IDX_CONTROL_OUTPUT_STATE       12'h012
// word indices of the support registers
`define IDX_IRQ_STATUS                 12'h020
`define IDX_IRQ_ENABLE                 12'h021
`define IDX_IRQ_CLEAR                  12'h022
`define IDX_BANK_CONFIG                12'h023
`define IDX_HEATER_CURRENT             12'h024

// field widths
`define CHANNEL_COUNT                  4
`define UNIT_COUNT                     8
`define OUTPUT_COUNT                   4
`define IRQ_COUNT                      4
`define WORD_WIDTH                     16

// interrupt status bit positions
`define IRQ_BIT_CHANNEL_ERROR          0
`define IRQ_BIT_UNIT_ERROR             1
`define IRQ_BIT_UNIT_ALARM             2
`define IRQ_BIT_HEATER_HOLD            3

// configuration bit positions
`define CFG_BIT_LINEAR_OUTPUTS         0
`define CFG_BIT_CT_ASSIGN_ENABLE       1

// reset values
`define RST_IRQ_ENABLE                 4'h0
`define RST_BANK_CONFIG                2'h2
`define RST_HEATER_CURRENT             16'h0000

// on-time below which the heater current is not updated
`define ONTIME_MIN_MS                  100

`endif

/* File: hw/unit_status_pkg.sv */
// types shared by the unit status word bank
// assumes the defines header is on the include path
`default_nettype none
`include "unit_status_defs.svh"

package unit_status_pkg;

   typedef logic [`WORD_WIDTH-1:0] status_word_type;
   typedef logic [11:0]            word_index_type;

   // byte address to word index; low two bits must be zero
   function automatic word_index_type word_index(input logic [13:0] addr);
      word_index = addr[13:2];
   endfunction

   // a bit that went from 0 to 1 since the previous sample
   function automatic logic any_rise(input logic [7:0] now_v,
                                     input logic [7:0] prev_v);
      any_rise = |(now_v & ~prev_v);
   endfunction

endpackage

`default_nettype wire

/* File: hw/heater_hold_if.sv */
// link between the status bank and the heater current hold module
// both ends run on the same clock
`default_nettype none

interface heater_hold_if;
   logic [15:0] sample_value;
   logic        sample_valid;
   logic        hold_req;
   logic [15:0] held_value;
   logic        holding;

   modport monitor (
      input  sample_value,
      input  sample_valid,
      input  hold_req,
      output held_value,
      output holding
   );
   modport bank (
      output sample_value,
      output sample_valid,
      output hold_req,
      input  held_value,
      input  holding
   );
endinterface

`default_nettype wire

/* File: hw/heater_current_hold.sv */
// heater current monitor value with hold
// assumes samples arrive already synchronous to core_clk_i
`default_nettype none
`include "unit_status_defs.svh"

module heater_current_hold
   import unit_status_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // link to the bank
   heater_hold_if.monitor   hold_link
);

   logic [15:0] value_r;
   logic        holding_r;

   // take new samples only while no hold condition stands
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         value_r <= `RST_HEATER_CURRENT;
      end
      else if (hold_link.sample_valid && !hold_link.hold_req)
      begin
         value_r <= hold_link.sample_value;
      end
   end

   // hold indication follows the request
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         holding_r <= 1'b0;
      end
      else
      begin
         holding_r <= hold_link.hold_req;
      end
   end

   assign hold_link.held_value = value_r;
   assign hold_link.holding    = holding_r;

endmodule // heater_current_hold

`default_nettype wire

/* File: bench/unit_status_word_bank_assertions.sv */
// checker bound to the status word bank ports
// assumes one apb master and pins held a few cycles
`default_nettype none
module unit_status_checker (
   // clock and reset
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   // apb and interrupt
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [13:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        irq_o,
   // watched pins
   input wire logic [3:0]  channel_error_i,
   input wire logic [3:0]  control_output_i
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] prev_r;
   logic [2:0] age_r;
   logic       rd;
   // a read answer in this cycle
   assign rd = pready_o && !pwrite_i;
   // cycles since the watched pins last moved
   always_ff @(posedge core_clk_i)
   begin
      prev_r <= {channel_error_i, control_output_i};
      if (rst_i || prev_r != {channel_error_i, control_output_i})
         age_r <= 3'h0;
      else if (age_r != 3'h7)
         age_r <= age_r + 3'h1;
   end
   ready_wait_a:
      assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
      else $error("pready not in second access cycle");
   ready_pulse_a:
      assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   idle_quiet_a:
      assert property (!psel_i |-> !pready_o && prdata_o == 32'h0)
      else $error("answer while not selected");
   err_zero_a:
      assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
      else $error("error without ready or with data");
   misalign_err_a:
      assert property (pready_o && paddr_i[1:0] != 2'h0 |-> pslverr_o)
      else $error("misaligned access not refused");
   unit_unused_a:
      assert property (pready_o && (paddr_i == 14'h003C
         || paddr_i == 14'h0040) |-> !pslverr_o && prdata_o[31:8] == 24'h0)
      else $error("unit word upper bits not zero");
   ch_follow_a:
      assert property (rd && paddr_i == 14'h002C && age_r > 3'h4
         |-> prdata_o == {28'h0, channel_error_i})
      else $error("channel error word wrong");
   out_follow_a:
      assert property (rd && paddr_i == 14'h0048 && age_r > 3'h4
         |-> prdata_o[31:2] == {28'h0, control_output_i[3:2]})
      else $error("output state word wrong");
   // main scenarios reached
   cover property (rd && paddr_i == 14'h0048);
   cover property (pslverr_o && pwrite_i);
   cover property ($rose(irq_o));
endmodule // unit_status_checker

bind unit_status_word_bank unit_status_checker chk (
   .core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .prdata_o, .pready_o, .pslverr_o, .irq_o, .channel_error_i,
   .control_output_i
);
`default_nettype wire

/* File: bench/apb_host_model.sv */
// apb master standing for the host that reads the status words
// assumes one clock shared with the bank
`default_nettype none
module apb_host_model (
   // clock
   input  wire logic        clk_i,
   // apb master side
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [13:0]      paddr_o,
   output logic [31:0]      pwdata_o,
   input  wire logic        pready_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // bus idle at time zero
   initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = 49'h0;
   // one transfer: setup, access held until pready
   task automatic xfer(input logic w, input logic [13:0] a,
                       input logic [31:0] d);
      begin
         @(posedge clk_i);
         psel_o    <= 1'b1;
         pwrite_o  <= w;
         paddr_o   <= a;
         pwdata_o  <= d;
         @(posedge clk_i);
         penable_o <= 1'b1;
         // wait for pready; only the bench watchdog ends a hang
         do
         begin
            @(posedge clk_i);
         end
         while (pready_i !== 1'b1);
         psel_o    <= 1'b0;
         penable_o <= 1'b0;
         pwdata_o  <= ~d; // stale data must not look valid
      end
   endtask
endmodule // apb_host_model
`default_nettype wire

/* File: bench/unit_status_word_bank_tb.sv */
// self-checking bench for the unit status word bank
// assumes the host model and the bound checker are compiled with it
`default_nettype none
`include "unit_status_defs.svh"
module unit_status_word_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [13:0] A_CH  = {`IDX_CHANNEL_ERROR_FLAGS, 2'h0};
   localparam logic [13:0] A_UE  = {`IDX_EXPANSION_UNIT_ERROR_FLAGS, 2'h0};
   localparam logic [13:0] A_UA  = {`IDX_EXPANSION_UNIT_ALARM_FLAGS, 2'h0};
   localparam logic [13:0] A_OS  = {`IDX_CONTROL_OUTPUT_STATE, 2'h0};
   localparam logic [13:0] A_IST = {`IDX_IRQ_STATUS, 2'h0};
   localparam logic [13:0] A_IEN = {`IDX_IRQ_ENABLE, 2'h0};
   localparam logic [13:0] A_ICL = {`IDX_IRQ_CLEAR, 2'h0};
   localparam logic [13:0] A_CFG = {`IDX_BANK_CONFIG, 2'h0};
   localparam logic [13:0] A_HC  = {`IDX_HEATER_CURRENT, 2'h0};
   typedef struct {logic [31:0] d; logic e;} note_type;
   note_type    q[$];
   note_type    cur;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, irq;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  ch = 4'h0, ctl = 4'h0;
   logic [7:0]  zc = 8'h00, pc = 8'h00, ff = 8'h00, hb = 8'h00;
   logic [7:0]  oc = 8'h00, sh = 8'h00, ro = 8'h00;
   logic        ct = 1'b1, ots = 1'b0, hv = 1'b0;
   logic [3:0]  strb = 4'hF;
   logic [15:0] hs = 16'h0000;
   logic [13:0] aw [4];
   logic [31:0] w [4];
   int          errors = 0, n_compared = 0, seed = 61800;

   apb_host_model host (.clk_i(clk), .psel_o(psel), .penable_o(penable),
      .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
      .pready_i(pready));
   unit_status_word_bank DUT (.core_clk_i(clk), .rst_i(rst),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(strb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .irq_o(irq), .channel_error_i(ch), .unit_zero_cross_fault_i(zc),
      .unit_is_power_ctl_i(pc), .unit_freq_fault_i(ff),
      .unit_heater_burnout_i(hb), .unit_overcurrent_i(oc),
      .unit_relay_short_i(sh), .unit_relay_open_i(ro),
      .control_output_i(ctl), .ct_connected_i(ct),
      .heater_sample_i(hs), .heater_sample_valid_i(hv),
      .ontime_short_i(ots));

   // clock, 8 ns period
   initial forever #4 clk = ~clk;
   // compare one value
   task automatic check_word(input string nm, input logic [31:0] ex,
                             input logic [31:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== ex)
         begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
         end
      end
   endtask
   // note the expected answer, then run the transfer
   task automatic xact(input logic wr, input logic [13:0] a,
      input logic [31:0] d, input logic [31:0] ex, input logic e);
      begin
         q.push_back('{ex, e});
         host.xfer(wr, a, d);
      end
   endtask
   // one heater current sample pulse
   task automatic sample(input logic [15:0] v);
      begin
         @(posedge clk);
         hs <= v;
         hv <= 1'b1;
         @(posedge clk);
         hv <= 1'b0;
      end
   endtask
   // verdict and end of run
   task automatic stop_test;
      begin
         if (errors == 0 && n_compared > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // each answer against the oldest note
   always @(posedge clk)
   begin
      if (pready === 1'b1)
      begin
         cur = q.pop_front();
         check_word("prdata", cur.d, prdata);
         check_word("pslverr", {31'h0, cur.e}, {31'h0, pslverr});
      end
   end
   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      errors = errors + 1;
      stop_test;
   end
   // main sequence
   initial
   begin
      aw = '{A_CH, A_UE, A_UA, A_OS};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      xact(1'b0, A_IEN, 32'h0, 32'h0, 1'b0);
      xact(1'b0, A_CFG, 32'h0, 32'h2, 1'b0);
      xact(1'b0, A_HC, 32'h0, 32'h0, 1'b0);
      xact(1'b0, A_ICL, 32'h0, 32'h0, 1'b0);
      xact(1'b0, 14'h002D, 32'h0, 32'h0, 1'b1);
      xact(1'b0, 14'h0030, 32'h0, 32'h0, 1'b1);
      xact(1'b1, 14'h01FC, 32'hFFFFFFFF, 32'h0, 1'b1);
      // status words follow random pins, then in linear mode
      for (int k = 0; k < 8; k++)
      begin
         if (k == 4)
            xact(1'b1, A_CFG, 32'h1, 32'h0, 1'b0);
         {ch, zc, pc, ff, hb, oc, sh, ro, ctl} <=
            {$random(seed), $random(seed)};
         repeat (5) @(posedge clk);
         w[0] = {28'h0, ch};
         w[1] = {24'h0, zc};
         w[2] = {24'h0, hb | oc | sh | (ro & pc)};
         w[3] = {28'h0, ctl & ((k < 4) ? 4'hF : 4'hC)};
         for (int j = 0; j < 4; j++)
            xact(1'b0, aw[j], 32'h0, w[j], 1'b0);
         xact(1'b1, aw[k % 4], $random(seed), 32'h0, 1'b0);
         xact(1'b0, aw[k % 4], 32'h0, w[k % 4], 1'b0);
      end
      // heater current held while any hold cause stands
      xact(1'b1, A_CFG, 32'h2, 32'h0, 1'b0);
      {ff, pc, ct, ots} <= {8'h00, 8'h10, 2'b10};
      repeat (4) @(posedge clk);
      sample(16'h1234);
      xact(1'b0, A_HC, 32'h0, 32'h1234, 1'b0);
      for (int c = 0; c < 5; c++)
      begin
         ots <= (c == 0);
         ct  <= (c != 1);
         ff  <= (c == 2) ? 8'h10 : 8'h20;
         if (c == 3)
            xact(1'b1, A_CFG, 32'h0, 32'h0, 1'b0);
         if (c == 4)
            xact(1'b1, A_CFG, 32'h2, 32'h0, 1'b0);
         repeat (4) @(posedge clk);
         sample({12'hA00, c[3:0]});
         xact(1'b0, A_HC, 32'h0, (c == 4) ? 32'hA004 : 32'h1234,
            1'b0);
      end
      // interrupt raised, masked and cleared
      {ch, zc, hb, oc, sh, ro} <= 44'h0;
      repeat (6) @(posedge clk);
      xact(1'b1, A_ICL, 32'hF, 32'h0, 1'b0);
      xact(1'b0, A_IST, 32'h0, 32'h0, 1'b0);
      xact(1'b1, A_IEN, 32'hF, 32'h0, 1'b0);
      ch <= 4'h4;
      repeat (6) @(posedge clk);
      check_word("irq", 32'h1, {31'h0, irq});
      xact(1'b0, A_IST, 32'h0, 32'h1, 1'b0);
      xact(1'b1, A_IEN, 32'h0, 32'h0, 1'b0);
      repeat (2) @(posedge clk);
      check_word("irq", 32'h0, {31'h0, irq});
      xact(1'b1, A_IEN, 32'hF, 32'h0, 1'b0);
      xact(1'b1, A_ICL, 32'h1, 32'h0, 1'b0);
      repeat (2) @(posedge clk);
      check_word("irq", 32'h0, {31'h0, irq});
      // a write with the low strobe off leaves the enable alone
      strb <= 4'hE;
      xact(1'b1, A_IEN, 32'h0, 32'h0, 1'b0);
      strb <= 4'hF;
      xact(1'b0, A_IEN, 32'h0, 32'hF, 1'b0);
      // mid-run reset restores the enable register
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      xact(1'b0, A_IEN, 32'h0, 32'h0, 1'b0);
      xact(1'b0, A_CFG, 32'h0, 32'h2, 1'b0);
      check_word("irq", 32'h0, {31'h0, irq});
      repeat (4) @(posedge clk);
      stop_test;
   end
endmodule // unit_status_word_bank_tb
`default_nettype wire
